// *** hw/step_sup_defs.svh ***
// Purpose: Offsets, fields, reset values and timing counts of the step switch supervisor
// Assumes: 40 MHz core clock, byte-addressed plain register port
// Notes:   Times are kept in their own unit and converted where used
`ifndef STEP_SUP_DEFS_SVH
`define STEP_SUP_DEFS_SVH

// Register byte offsets
`define ADR_CTRL    8'h00
`define ADR_STATUS  8'h04
`define ADR_STEPS   8'h08
`define ADR_FIXOFF  8'h0c
`define ADR_LOG     8'h10
`define ADR_DISCH   8'h14
`define ADR_LOCK    8'h18

// Status field positions
`define ST_MAN_BIT  16
`define ST_HALT_BIT 17
`define ST_SEL_LSB  18

// Reset values
`define PFC_RST     2'h0
`define DISCH_RST   8'h3c

// Timing
`define CLK_HZ      40000000
`define TIME_SEC    1
`define SEC_CYCLES  (`TIME_SEC * `CLK_HZ)
`define SEC_PER_MIN 60
`define HOLD_SEC    3
`define IDLE_MIN    10
`define IDLE_SEC    (`IDLE_MIN * `SEC_PER_MIN)
`define LOCK_MIN    30
`define FAULT_HOURS 24
`define FAULT_MIN   (`FAULT_HOURS * 60)
`define LOG_DEPTH   5

`endif

// *** hw/step_sup_pkg.sv ***
// Purpose: Types shared by the step switch supervisor
// Assumes: Nothing
// Notes:   Alarm code n maps to alarm vector bit n-1
package step_sup_pkg;
  typedef enum logic [1:0] {
    PFC_ON   = 2'b00,
    PFC_OFF  = 2'b01,
    PFC_HOLD = 2'b10
  } pfc_mode_t;

  typedef enum logic {
    MAN_AUTO   = 1'b0,
    MAN_ACTIVE = 1'b1
  } man_state_t;

  typedef enum logic [3:0] {
    ALM_NONE   = 4'h0,
    ALM_ABORT  = 4'h1,
    ALM_VOLT   = 4'h2,
    ALM_ILO    = 4'h3,
    ALM_IHI    = 4'h4,
    ALM_COMP   = 4'h5,
    ALM_THD    = 4'h6,
    ALM_FAULTY = 4'h7,
    ALM_SPL    = 4'h8,
    ALM_TEMP   = 4'h9,
    ALM_OPH    = 4'ha,
    ALM_OPC    = 4'hb,
    ALM_OVL    = 4'hc,
    ALM_HUNT   = 4'hd
  } alarm_code_t;
endpackage

// *** hw/sec_timebase.sv ***
// Purpose: Second and minute pulses from the core clock
// Assumes: SEC_CYCLES core cycles per second
// Notes:   Pulses are one core cycle wide
`timescale 1ns/1ps
`include "step_sup_defs.svh"
module sec_timebase #(
  parameter int SEC_CYCLES = `SEC_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  output logic      secTick,
  output logic      minTick
);
  logic [25:0] div_r;
  logic [5:0]  secCnt_r;
  wire         divEnd = (div_r == 26'(SEC_CYCLES - 1));
  wire         secEnd = (secCnt_r == 6'(`SEC_PER_MIN - 1));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_r    <= 26'h0;
      secCnt_r <= 6'h0;
      secTick  <= 1'b0;
      minTick  <= 1'b0;
    end else begin
      div_r    <= divEnd ? 26'h0 : div_r + 26'h1;
      secTick  <= divEnd;
      minTick  <= divEnd & secEnd;
      if (divEnd) begin
        secCnt_r <= secEnd ? 6'h0 : secCnt_r + 6'h1;
      end
    end
  end
endmodule

// *** hw/step_switch_supervisor.sv ***
// Purpose: Supervises manual and automatic switching of capacitor steps and the alarms
// Assumes: Keys and measurement flags are synchronous to core_clk
// Notes:   Registers on a plain port, read data one cycle after the read strobe
`timescale 1ns/1ps
`include "step_sup_defs.svh"
module step_switch_supervisor #(
  parameter int N          = 12,
  parameter int SEC_CYCLES = `SEC_CYCLES
) (
  input  wire logic           core_clk,
  input  wire logic           nrst,
  input  wire logic [7:0]     regAddr,
  input  wire logic [31:0]    regWdata,
  input  wire logic           regWr,
  input  wire logic           regRd,
  output logic      [31:0]    regRdata,
  input  wire logic           keyUp,
  input  wire logic           keyDown,
  input  wire logic           keySel,
  input  wire logic           keyEsc,
  input  wire logic           menuManual,
  input  wire logic           lastInFirstOut,
  input  wire logic           autoInitRunning,
  input  wire logic           autoInitAbort,
  input  wire logic           voltageOk,
  input  wire logic           currentLow,
  input  wire logic           currentHigh,
  input  wire logic           compFail,
  input  wire logic           thdExceeded,
  input  wire logic           tempExceeded,
  input  wire logic           overloadExceeded,
  input  wire logic           hoursExceeded,
  input  wire logic [N-1:0]   cyclesExceeded,
  input  wire logic [N-1:0]   stepBroken,
  input  wire logic [N-1:0]   stepPowerLoss,
  input  wire logic [N-1:0]   stepHunting,
  input  wire logic [N-1:0]   stepTypeAuto,
  input  wire logic [N-1:0]   autoStepReq,
  output logic      [N-1:0]   stepOut,
  output logic      [N-1:0]   stepFlash,
  output logic                manualMode,
  output logic                ctrlHalted,
  output logic                dispAlarm,
  output logic      [3:0]     dispCode
);
  localparam int SW = (N > 1) ? $clog2(N) : 1;

  function automatic logic [N-1:0] topBit(input logic [N-1:0] v);
    logic [N-1:0] r;
    r = '0;
    for (int i = 0; i < N; i++) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] lowCode(input logic [12:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 12; i >= 0; i--) begin
      if (v[i]) begin
        c = 4'(i + 1);
      end
    end
    return c;
  endfunction

  logic                     secTick;
  logic                     minTick;
  step_sup_pkg::pfc_mode_t  pfcMode_r;
  step_sup_pkg::man_state_t manState_r;
  logic                     upPrev_r;
  logic                     downPrev_r;
  logic                     selPrev_r;
  logic [1:0]               selHold_r;
  logic [1:0]               bothHold_r;
  logic [9:0]               idleSec_r;
  logic [SW-1:0]            selStep_r;
  logic [N-1:0]             stepOn_r;
  logic [N-1:0]             stepNxt;
  logic [N-1:0]             fixOff_r;
  logic [7:0]               dischSec_r;
  logic [7:0]               dischCnt_r [N];
  logic [10:0]              faultCnt_r [N];
  logic [5:0]               grpLockCnt_r;
  logic                     abortAlarm_r;
  logic [12:0]              alarmPrev_r;
  logic [3:0]               log_r [`LOG_DEPTH];
  logic                     blink_r;
  logic [N-1:0]             dischDone;
  logic [N-1:0]             faultLocked;

  sec_timebase #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_timebase (
    .core_clk (core_clk),
    .nrst     (nrst),
    .secTick  (secTick),
    .minTick  (minTick)
  );

  // Key edges and hold detection
  wire upPress   = keyUp & ~upPrev_r;
  wire downPress = keyDown & ~downPrev_r;
  wire selPress  = keySel & ~selPrev_r;
  wire navPress  = upPress | downPress | selPress | keyEsc;
  wire bothKeys  = keyUp & keyDown;
  wire selHeld   = (selHold_r == 2'(`HOLD_SEC));
  wire bothHeld  = (bothHold_r == 2'(`HOLD_SEC));
  wire bothFire  = bothKeys & secTick & (bothHold_r == 2'(`HOLD_SEC - 1));

  wire inManual  = (manState_r == step_sup_pkg::MAN_ACTIVE);
  wire lifoBlock = lastInFirstOut & autoInitRunning;
  wire manEnter  = ~inManual & menuManual & keySel & selHeld & ~lifoBlock;
  wire idleOut   = (idleSec_r == 10'(`IDLE_SEC));
  wire manLeave  = inManual & (keyEsc | idleOut);

  // Alarm conditions
  wire hunting   = |stepHunting;
  wire shedCond  = thdExceeded | tempExceeded | overloadExceeded;
  wire grpLocked = shedCond | (grpLockCnt_r != 6'h0);
  wire [12:0] alarmVec = {
    hunting,
    overloadExceeded,
    |cyclesExceeded,
    hoursExceeded,
    tempExceeded,
    |stepPowerLoss,
    |stepBroken,
    thdExceeded,
    compFail,
    currentHigh,
    currentLow,
    ~voltageOk,
    abortAlarm_r
  };
  wire anyAlarm  = |alarmVec;
  wire [12:0] alarmNew = alarmVec & ~alarmPrev_r;

  // Manual gating
  wire manBlock  = ~voltageOk | lifoBlock | shedCond | hunting;
  wire selIsOn   = stepOn_r[selStep_r];
  wire selTypeOk = stepTypeAuto[selStep_r];
  wire selFree   = ~faultLocked[selStep_r] & ~fixOff_r[selStep_r];
  wire selOnOk   = dischDone[selStep_r] & ~grpLocked;
  wire manTog    = inManual & selPress & ~manBlock & selTypeOk & selFree
                   & (selIsOn | selOnOk);

  // Control state
  wire modeOn    = (pfcMode_r == step_sup_pkg::PFC_ON);
  wire modeOff   = (pfcMode_r == step_sup_pkg::PFC_OFF);
  wire haltNow   = inManual | ~voltageOk | ~modeOn;
  wire shedReq   = modeOff | currentLow | shedCond;
  wire [N-1:0] forcedOff = faultLocked | fixOff_r;

  // Register decode
  wire wrCtrl    = regWr & (regAddr == `ADR_CTRL);
  wire wrFixOff  = regWr & (regAddr == `ADR_FIXOFF);
  wire wrDisch   = regWr & (regAddr == `ADR_DISCH);
  wire [19:0] logPacked = {log_r[4], log_r[3], log_r[2], log_r[1], log_r[0]};
  wire [31:0] statusWord = {{(32 - `ST_SEL_LSB - SW){1'b0}}, selStep_r, ctrlHalted,
                            inManual, 3'h0, alarmVec};
  wire [31:0] rdMux =
    (regAddr == `ADR_CTRL)   ? {30'h0, pfcMode_r} :
    (regAddr == `ADR_STATUS) ? statusWord :
    (regAddr == `ADR_STEPS)  ? {{(32 - N){1'b0}}, stepOn_r} :
    (regAddr == `ADR_FIXOFF) ? {{(32 - N){1'b0}}, fixOff_r} :
    (regAddr == `ADR_LOG)    ? {12'h0, logPacked} :
    (regAddr == `ADR_DISCH)  ? {24'h0, dischSec_r} :
    (regAddr == `ADR_LOCK)   ? {{(32 - N){1'b0}}, forcedOff | {N{grpLocked}}} :
                               32'h0;

  // Next step state
  always_comb begin
    stepNxt = stepOn_r;
    if (shedReq) begin
      if (secTick) begin
        stepNxt = stepOn_r & ~topBit(stepOn_r);
      end
    end else if (manTog) begin
      stepNxt[selStep_r] = ~selIsOn;
    end else if (!haltNow) begin
      stepNxt = autoStepReq & (stepOn_r | (dischDone & ~{N{grpLocked}}));
    end
    stepNxt = stepNxt & ~forcedOff;
  end

  // Keys, holds and idle timer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      upPrev_r   <= 1'b0;
      downPrev_r <= 1'b0;
      selPrev_r  <= 1'b0;
      selHold_r  <= 2'h0;
      bothHold_r <= 2'h0;
      idleSec_r  <= 10'h0;
    end else begin
      upPrev_r   <= keyUp;
      downPrev_r <= keyDown;
      selPrev_r  <= keySel;
      if (!keySel) begin
        selHold_r <= 2'h0;
      end else if (secTick && !selHeld) begin
        selHold_r <= selHold_r + 2'h1;
      end
      if (!bothKeys) begin
        bothHold_r <= 2'h0;
      end else if (secTick && !bothHeld) begin
        bothHold_r <= bothHold_r + 2'h1;
      end
      if (!inManual || navPress) begin
        idleSec_r <= 10'h0;
      end else if (secTick && !idleOut) begin
        idleSec_r <= idleSec_r + 10'h1;
      end
    end
  end

  // Manual mode and step selection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      manState_r <= step_sup_pkg::MAN_AUTO;
      selStep_r  <= '0;
    end else begin
      case (manState_r)
        step_sup_pkg::MAN_AUTO: begin
          if (manEnter) begin
            manState_r <= step_sup_pkg::MAN_ACTIVE;
            selStep_r  <= '0;
          end
        end
        step_sup_pkg::MAN_ACTIVE: begin
          if (manLeave) begin
            manState_r <= step_sup_pkg::MAN_AUTO;
          end else if (upPress && !keyDown) begin
            selStep_r <= (selStep_r == SW'(N - 1)) ? '0 : selStep_r + SW'(1);
          end else if (downPress && !keyUp) begin
            selStep_r <= (selStep_r == '0) ? SW'(N - 1) : selStep_r - SW'(1);
          end
        end
        default: manState_r <= step_sup_pkg::MAN_AUTO;
      endcase
    end
  end

  // Control mode and abort alarm; the abort wins over a software write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pfcMode_r    <= step_sup_pkg::pfc_mode_t'(`PFC_RST);
      abortAlarm_r <= 1'b0;
      dischSec_r   <= `DISCH_RST;
    end else begin
      if (autoInitAbort) begin
        pfcMode_r    <= step_sup_pkg::PFC_OFF;
        abortAlarm_r <= 1'b1;
      end else if (wrCtrl) begin
        pfcMode_r    <= (regWdata[1:0] == 2'h3) ? step_sup_pkg::PFC_HOLD
                        : step_sup_pkg::pfc_mode_t'(regWdata[1:0]);
        abortAlarm_r <= 1'b0;
      end
      if (wrDisch) begin
        dischSec_r <= regWdata[7:0];
      end
    end
  end

  // Steps, discharge and per-step lockouts
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stepOn_r <= '0;
      fixOff_r <= '0;
      for (int i = 0; i < N; i++) begin
        dischCnt_r[i] <= 8'h0;
        faultCnt_r[i] <= 11'h0;
      end
    end else begin
      stepOn_r <= stepNxt;
      fixOff_r <= (fixOff_r & ~({N{wrFixOff}} & regWdata[N-1:0]))
                  | stepPowerLoss | stepHunting;
      for (int i = 0; i < N; i++) begin
        if (stepOn_r[i] && !stepNxt[i]) begin
          dischCnt_r[i] <= dischSec_r;
        end else if (secTick && dischCnt_r[i] != 8'h0) begin
          dischCnt_r[i] <= dischCnt_r[i] - 8'h1;
        end
        if (stepBroken[i]) begin
          faultCnt_r[i] <= 11'(`FAULT_MIN);
        end else if (minTick && faultCnt_r[i] != 11'h0) begin
          faultCnt_r[i] <= faultCnt_r[i] - 11'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      dischDone[i]   = (dischCnt_r[i] == 8'h0);
      faultLocked[i] = stepBroken[i] | (faultCnt_r[i] != 11'h0);
    end
  end

  // Group lockout, log and display
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      grpLockCnt_r <= 6'h0;
      alarmPrev_r  <= 13'h0;
      blink_r      <= 1'b0;
      dispCode     <= 4'h0;
      for (int k = 0; k < `LOG_DEPTH; k++) begin
        log_r[k] <= 4'h0;
      end
    end else begin
      if (shedCond) begin
        grpLockCnt_r <= 6'(`LOCK_MIN);
      end else if (minTick && grpLockCnt_r != 6'h0) begin
        grpLockCnt_r <= grpLockCnt_r - 6'h1;
      end
      alarmPrev_r <= alarmVec;
      if (alarmNew != 13'h0) begin
        log_r[0] <= lowCode(alarmNew);
        for (int k = 1; k < `LOG_DEPTH; k++) begin
          log_r[k] <= log_r[k-1];
        end
      end else if (bothFire) begin
        for (int k = 0; k < `LOG_DEPTH; k++) begin
          log_r[k] <= 4'h0;
        end
      end
      if (!anyAlarm) begin
        blink_r <= 1'b0;
      end else if (secTick) begin
        blink_r <= ~blink_r;
      end
      dispCode <= lowCode(alarmVec);
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata   <= 32'h0;
      manualMode <= 1'b0;
      ctrlHalted <= 1'b0;
      stepFlash  <= '0;
    end else begin
      regRdata   <= regRd ? rdMux : 32'h0;
      manualMode <= inManual;
      ctrlHalted <= haltNow;
      stepFlash  <= (stepBroken | faultLocked | fixOff_r) & {N{blink_r}};
    end
  end

  assign stepOut   = stepOn_r;
  assign dispAlarm = blink_r;
endmodule

// *** dv/step_sup_chk.sv ***
// Purpose: Port assertions of the step switch supervisor
// Assumes: One clock domain, bound to the top module
// Notes:   Multi-cycle antecedents are named sequences, except those of a_code_alarm and a_fixoff_now
`timescale 1ns/1ps
module step_sup_chk #(
  parameter int N = 12
) (
  input wire logic         core_clk,
  input wire logic         nrst,
  input wire logic [7:0]   regAddr,
  input wire logic         regRd,
  input wire logic [31:0]  regRdata,
  input wire logic         voltageOk,
  input wire logic         currentLow,
  input wire logic         thdExceeded,
  input wire logic [N-1:0] stepBroken,
  input wire logic [N-1:0] stepPowerLoss,
  input wire logic [N-1:0] stepHunting,
  input wire logic [N-1:0] stepTypeAuto,
  input wire logic [N-1:0] stepOut,
  input wire logic         manualMode,
  input wire logic         ctrlHalted,
  input wire logic         dispAlarm,
  input wire logic [3:0]   dispCode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic [N-1:0] forced   = stepPowerLoss | stepHunting;
  wire logic         unmapped = (regAddr > 8'h18) || (regAddr[1:0] != 2'h0);
  sequence s_volt_bad;
    !voltageOk [*3];
  endsequence
  sequence s_thd;
    thdExceeded [*2];
  endsequence
  sequence s_man;
    manualMode [*3];
  endsequence
  sequence s_low;
    (currentLow && stepBroken == '0 && forced == '0) ##1 (currentLow && forced == '0);
  endsequence
  a_read_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (regRd && unmapped |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  a_volt_halt: assert property (s_volt_bad |-> ctrlHalted)
    else $error("control running on bad voltage");
  a_volt_noon: assert property (s_volt_bad |-> (stepOut & ~$past(stepOut)) == '0)
    else $error("step switched on with bad voltage");
  a_thd_noon: assert property (s_thd |-> (stepOut & ~$past(stepOut)) == '0)
    else $error("step switched on during distortion");
  a_type_manual: assert property (s_man |->
    (stepOut & ~$past(stepOut) & ~$past(stepTypeAuto)) == '0)
    else $error("non automatic step switched in manual");
  a_manual_halt: assert property ($rose(manualMode) |-> ##[0:2] ctrlHalted)
    else $error("manual entry did not halt control");
  a_code_alarm: assert property (dispCode == 4'h0 ##1 dispCode == 4'h0 |-> !dispAlarm)
    else $error("alarm indication without alarm");
  a_fixoff_now: assert property ((forced != '0) ##3 1'b1 |->
    (stepOut & $past(forced, 3)) == '0)
    else $error("forced off step still on");
  a_low_shed: assert property (s_low |-> $countones($past(stepOut) & ~stepOut) <= 1)
    else $error("more than one step opened at once");
endmodule
bind step_switch_supervisor step_sup_chk #(.N(N)) uChk (
  .core_clk, .nrst, .regAddr, .regRd, .regRdata, .voltageOk, .currentLow,
  .thdExceeded, .stepBroken, .stepPowerLoss, .stepHunting, .stepTypeAuto,
  .stepOut, .manualMode, .ctrlHalted, .dispAlarm, .dispCode
);

// *** dv/panel_model.sv ***
// Purpose: Front panel keys worked by an operator
// Assumes: Keys change just after a rising clock edge
// Notes:   Key mask order is esc, sel, down, up
`timescale 1ns/1ps
module panel_model (
  input  wire logic core_clk,
  output logic      keyUp,
  output logic      keyDown,
  output logic      keySel,
  output logic      keyEsc,
  output logic      menuManual
);
  initial begin
    {keyEsc, keySel, keyDown, keyUp} = 4'h0;
    menuManual = 1'b0;
  end
  // Choose or leave the manual menu item
  task automatic setMenu(input logic on);
    menuManual <= on;
  endtask
  // Hold the masked keys, release, then rest
  task automatic hold(input logic [3:0] mask, input int cyc);
    @(posedge core_clk);
    {keyEsc, keySel, keyDown, keyUp} <= mask;
    repeat (cyc) @(posedge core_clk);
    {keyEsc, keySel, keyDown, keyUp} <= 4'h0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule

// *** dv/step_switch_supervisor_tb.sv ***
// Purpose: Self-checking bench of the step switch supervisor
// Assumes: A short second of SC cycles
// Notes:   Expected results queue up and are compared as outputs appear
`timescale 1ns/1ps
module step_switch_supervisor_tb;
  localparam int N = 12;
  localparam int SC = 8;
  localparam int SO = 1, MM = 2, CH = 3, DC = 4, SK = 5, FL = 6, DA = 7;
  localparam logic [3:0] UP = 4'h1, SEL = 4'h4, ESC = 4'h8;
  localparam step_sup_pkg::alarm_code_t CODES [4] = '{step_sup_pkg::ALM_IHI,
    step_sup_pkg::ALM_COMP, step_sup_pkg::ALM_OPH, step_sup_pkg::ALM_OPC};
  logic         core_clk, nrst, regWr, regRd, rdSeen, pReq, voltageOk;
  logic         lastInFirstOut, autoInitRunning, autoInitAbort, currentLow, dispAlarm;
  logic         keyUp, keyDown, keySel, keyEsc, menuManual, manualMode, ctrlHalted;
  logic [7:0]   regAddr;
  logic [31:0]  regWdata, regRdata, seed, q[$];
  logic [3:0]   alm, dispCode;
  logic [2:0]   shed;
  logic [N-1:0] stepHunting, stepTypeAuto, autoStepReq, stepOut, expOn, stepFlash;
  int           n_mismatch, total_checks, pSrc, k;

  step_switch_supervisor #(.N(N), .SEC_CYCLES(SC)) uut (
    .core_clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .keyUp, .keyDown, .keySel, .keyEsc, .menuManual, .lastInFirstOut,
    .autoInitRunning, .autoInitAbort, .voltageOk, .currentLow,
    .currentHigh(alm[0]), .compFail(alm[1]), .hoursExceeded(alm[2]),
    .cyclesExceeded({{(N - 1){1'b0}}, alm[3]}), .thdExceeded(shed[0]),
    .tempExceeded(shed[1]), .overloadExceeded(shed[2]), .stepBroken('0),
    .stepPowerLoss('0), .stepHunting, .stepTypeAuto, .autoStepReq, .stepOut,
    .stepFlash, .manualMode, .ctrlHalted, .dispAlarm, .dispCode
  );
  panel_model uPanel (.core_clk, .keyUp, .keyDown, .keySel, .keyEsc, .menuManual);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] obs(input int s);
    case (s)
      SO: return 32'(stepOut);
      MM: return {31'h0, manualMode};
      CH: return {31'h0, ctrlHalted};
      DC: return {28'h0, dispCode};
      FL: return 32'(stepFlash);
      DA: return {31'h0, dispAlarm};
      default: return {31'h0, stepOut[k]};
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Compare the oldest note with whichever result shows now
  always @(posedge core_clk) rdSeen <= regRd;
  always @(negedge core_clk) begin
    if (rdSeen || pReq) begin
      if (q.size() == 0) begin
        n_mismatch++;
        $display("[ERR] %0t result with no note", $time);
      end else check(rdSeen ? regRdata : obs(pSrc), q.pop_front());
      pReq = 1'b0;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    q.push_back(e);
    @(posedge core_clk);
    regRd <= 1'b0;
    cyc(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic chk(input int s, input logic [31:0] e);
    q.push_back(e);
    pSrc = s;
    pReq = 1'b1;
    @(negedge core_clk);
    @(posedge core_clk);
  endtask
  task automatic waitfor(input int s, input logic [31:0] e, input int lim);
    int i;
    i = 0;
    @(negedge core_clk);
    while (i < lim && obs(s) !== e) begin
      @(negedge core_clk);
      i++;
    end
    if (obs(s) !== e) begin
      n_mismatch++;
      $display("[ERR] %0t wait ran out", $time);
      summarize();
    end
    @(posedge core_clk);
  endtask
  task automatic enter();
    uPanel.setMenu(1'b1);
    uPanel.hold(SEL, 5 * SC);
  endtask

  initial begin
    seed = 32'h26dc;
    {nrst, regWr, regRd, rdSeen, pReq, voltageOk} = 6'h1;
    {lastInFirstOut, autoInitRunning, autoInitAbort, currentLow} = 4'h0;
    {regAddr, regWdata, alm, shed} = '0;
    {stepHunting, autoStepReq, expOn} = '0;
    stepTypeAuto = {{(N - 1){1'b1}}, 1'b0};
    {n_mismatch, total_checks, k} = '0;
    cyc(16);
    nrst <= 1'b1;
    void'(xs());
    autoStepReq <= seed[N-1:0];
    rd(8'h00, {30'h0, step_sup_pkg::PFC_ON});
    rd(8'h14, 32'h3c);
    chk(SO, 32'(autoStepReq));
    void'(xs());
    wr(8'h20, seed);
    rd(8'h20, 32'h0);
    wr(8'h14, seed);
    rd(8'h14, {24'h0, seed[7:0]});
    wr(8'h14, 32'h3c);
    for (int i = 0; i < 4; i++) begin
      alm <= 4'h1 << i;
      cyc(3);
      chk(DC, {28'h0, CODES[i]});
      chk(CH, 32'h0);
      alm <= 4'h0;
      cyc(3);
    end
    rd(8'h10, {16'h0, CODES[0], CODES[1], CODES[2], CODES[3]});
    uPanel.hold(4'h3, 4 * SC);
    rd(8'h10, 32'h0);
    autoInitAbort <= 1'b1;
    cyc(1);
    autoInitAbort <= 1'b0;
    cyc(3);
    chk(DC, {28'h0, step_sup_pkg::ALM_ABORT});
    rd(8'h00, {30'h0, step_sup_pkg::PFC_OFF});
    wr(8'h00, 32'h3);
    rd(8'h00, {30'h0, step_sup_pkg::PFC_HOLD});
    wr(8'h00, 32'h0);
    cyc(3);
    chk(DC, 32'h0);
    autoStepReq <= '0;
    cyc(62 * SC);
    {lastInFirstOut, autoInitRunning} <= 2'h3;
    enter();
    chk(MM, 32'h0);
    {lastInFirstOut, autoInitRunning} <= 2'h0;
    enter();
    waitfor(MM, 32'h1, 4 * SC);
    chk(CH, 32'h1);
    rd(8'h04, 32'h30000);
    uPanel.hold(SEL, 2);
    chk(SO, 32'h0);
    void'(xs());
    k = 1 + int'(seed % (N - 1));
    repeat (k) uPanel.hold(UP, 2);
    expOn[k] = 1'b1;
    uPanel.hold(SEL, 2);
    chk(SO, 32'(expOn));
    uPanel.hold(SEL, 2);
    chk(SO, 32'h0);
    uPanel.hold(SEL, 2);
    chk(SO, 32'h0);
    cyc(62 * SC);
    uPanel.hold(SEL, 2);
    chk(SO, 32'(expOn));
    voltageOk <= 1'b0;
    cyc(3);
    chk(DC, {28'h0, step_sup_pkg::ALM_VOLT});
    uPanel.hold(SEL, 2);
    chk(SO, 32'(expOn));
    voltageOk <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      shed <= 3'h1 << i;
      waitfor(SO, 32'h0, 3 * SC);
      uPanel.hold(SEL, 2);
      chk(SO, 32'h0);
      shed <= 3'h0;
      cyc(2);
    end
    cyc(62 * SC);
    uPanel.hold(SEL, 2);
    chk(SO, 32'h0);
    rd(8'h18, 32'({N{1'b1}}));
    waitfor(MM, 32'h0, 620 * SC);
    chk(CH, 32'h0);
    enter();
    waitfor(MM, 32'h1, 4 * SC);
    uPanel.hold(ESC, 2);
    chk(MM, 32'h0);
    nrst <= 1'b0;
    autoStepReq <= expOn;
    cyc(2);
    nrst <= 1'b1;
    cyc(2);
    rd(8'h08, 32'(expOn));
    stepHunting <= expOn;
    cyc(4);
    chk(DC, {28'h0, step_sup_pkg::ALM_HUNT});
    chk(SK, 32'h0);
    waitfor(FL, 32'(expOn), 3 * SC);
    chk(FL, 32'(expOn));
    chk(DA, 32'h1);
    stepHunting <= '0;
    autoStepReq <= ~expOn;
    cyc(2);
    wr(8'h0c, 32'(expOn));
    currentLow <= 1'b1;
    cyc(3);
    chk(DC, {28'h0, step_sup_pkg::ALM_ILO});
    waitfor(SO, 32'h0, (N + 2) * SC);
    chk(SO, 32'h0);
    currentLow <= 1'b0;
    summarize();
  end
endmodule
